// File: src/adc_regs.svh
// Register offsets, field positions and reset values of the converter register bank.
// Assumes inclusion by its bare name from design files.
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH
`define SEL_RESULT 3'h0
`define SEL_STATUS 3'h1
`define SEL_CONFIG 3'h2
`define SEL_LOW 3'h3
`define SEL_HIGH 3'h4
`define SEL_HYST 3'h5
`define SEL_LOWEST 3'h6
`define SEL_HIGHEST 3'h7
`define PTR_RESET 8'h00
`define RESULT_RESET 12'h000
`define STATUS_RESET 2'h0
`define CONFIG_RESET 8'h00
`define LOW_RESET 12'h000
`define HIGH_RESET 12'hFFF
`define HYST_RESET 12'h000
`define LOWEST_RESET 12'hFFF
`define HIGHEST_RESET 12'h000
`define STAT_UNDER_BIT 0
`define STAT_OVER_BIT 1
`define CFG_FLAG_EN_BIT 3
`define CFG_HOLD_BIT 4
`define CFG_RSVD_BIT 1
`define RES_ALERT_BIT 15
`endif

// File: src/adc_pkg.sv
// Types shared by the converter register bank.
// Assumes the register header supplies every number.
package adc_pkg;
    typedef enum logic [1:0] {
        ph_idle,
        ph_pointer,
        ph_data_hi,
        ph_data_lo
    } wr_phase_t;
endpackage : adc_pkg

// File: src/limit_if.sv
// Carries limit settings and a new sample into the alert evaluator.
// Assumes one clock domain shared by all users.
`timescale 1ns/1ps
interface limit_if;
    logic sample_valid;
    logic [11:0] sample;
    logic [11:0] low_value;
    logic [11:0] high_value;
    logic [11:0] hyst_value;
    logic hold;
    logic [1:0] clear_w1;
    logic [1:0] flags;
    modport bank (output sample_valid, sample, low_value, high_value, hyst_value, hold,
                  clear_w1, input flags);
    modport eval (input sample_valid, sample, low_value, high_value, hyst_value, hold,
                  clear_w1, output flags);
endinterface : limit_if

// File: src/alert_eval.sv
// Alert status flags: set by limit violations, cleared by write-one or hysteresis.
// Assumes limits are stable while a sample is judged.
`timescale 1ns/1ps
`include "adc_regs.svh"
module alert_eval (
    input wire logic clock,
    input wire logic rst_b,
    limit_if.eval lim
);
    logic [12:0] high_clear;
    logic [12:0] low_clear;
    logic over_set;
    logic under_set;
    logic over_rel;
    logic under_rel;
    logic [1:0] flags_r;

    // Widened by one bit so the sum never wraps and bit 12 marks a difference below zero
    assign high_clear = {1'b0, lim.high_value} - {1'b0, lim.hyst_value};
    assign low_clear = {1'b0, lim.low_value} + {1'b0, lim.hyst_value};
    assign over_set = lim.sample_valid && (lim.sample > lim.high_value);
    assign under_set = lim.sample_valid && (lim.sample < lim.low_value);
    assign over_rel = lim.sample_valid && !lim.hold && !high_clear[12]
                      && ({1'b0, lim.sample} < high_clear);
    assign under_rel = lim.sample_valid && !lim.hold
                       && ({1'b0, lim.sample} > low_clear);

    // Set wins over any clear arriving in the same cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= `STATUS_RESET;
        end else begin
            if (over_set) begin
                flags_r[`STAT_OVER_BIT] <= 1'b1;
            end else if (lim.clear_w1[`STAT_OVER_BIT] || over_rel) begin
                flags_r[`STAT_OVER_BIT] <= 1'b0;
            end
            if (under_set) begin
                flags_r[`STAT_UNDER_BIT] <= 1'b1;
            end else if (lim.clear_w1[`STAT_UNDER_BIT] || under_rel) begin
                flags_r[`STAT_UNDER_BIT] <= 1'b0;
            end
        end
    end
    assign lim.flags = flags_r;
endmodule : alert_eval

// File: src/adc_reg_bank.sv
// Register bank of a 12-bit converter behind a byte-wide two-wire target.
// Assumes a byte framer outside: it marks transaction start, write bytes, read bytes.
`timescale 1ns/1ps
`include "adc_regs.svh"
module adc_reg_bank #(
    parameter int SAMPLE_W = 12
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic xfer_start,
    input wire logic wr_byte_valid,
    input wire logic [7:0] wr_byte,
    input wire logic rd_byte_req,
    output logic [7:0] rd_byte_r,
    output logic rd_byte_valid_r,
    output logic conv_start_r,
    input wire logic conv_done,
    input wire logic [SAMPLE_W-1:0] conv_sample,
    input wire logic powerdown,
    output logic alert_active_r
);
    logic [2:0] sel_r;
    adc_pkg::wr_phase_t phase_r;
    logic rd_lo_r;
    logic [7:0] hi_byte_r;
    logic [SAMPLE_W-1:0] result_r;
    logic [7:0] config_r;
    logic [SAMPLE_W-1:0] low_r;
    logic [SAMPLE_W-1:0] high_r;
    logic [SAMPLE_W-1:0] hyst_r;
    logic [SAMPLE_W-1:0] lowest_r;
    logic [SAMPLE_W-1:0] highest_r;
    logic [1:0] flags;
    logic [15:0] word_sel;
    logic [SAMPLE_W-1:0] wr_word;
    logic wr_commit;
    logic wide_sel;
    logic auto_mode;

    limit_if lim ();

    alert_eval u_alert (
        .clock(clock),
        .rst_b(rst_b),
        .lim(lim)
    );

    // Selected register as it reads, used by both read bytes
    function automatic logic [15:0] read_word(input logic [2:0] sel);
        logic [15:0] w;
        w = 16'h0000;
        case (sel)
            `SEL_RESULT: begin
                w[SAMPLE_W-1:0] = result_r;
                w[`RES_ALERT_BIT] = config_r[`CFG_FLAG_EN_BIT] && (|flags);
            end
            `SEL_STATUS: w[1:0] = flags;
            `SEL_CONFIG: w[7:0] = config_r;
            `SEL_LOW: w[SAMPLE_W-1:0] = low_r;
            `SEL_HIGH: w[SAMPLE_W-1:0] = high_r;
            `SEL_HYST: w[SAMPLE_W-1:0] = hyst_r;
            `SEL_LOWEST: w[SAMPLE_W-1:0] = lowest_r;
            `SEL_HIGHEST: w[SAMPLE_W-1:0] = highest_r;
            default: w = 16'h0000;
        endcase
        return w;
    endfunction : read_word

    assign word_sel = read_word(sel_r);
    assign flags = lim.flags;
    assign auto_mode = |config_r[7:5];
    // Status and config are one byte wide; the rest take two bytes, high first
    assign wide_sel = !(sel_r == `SEL_STATUS || sel_r == `SEL_CONFIG);
    assign wr_word = {hi_byte_r[SAMPLE_W-9:0], wr_byte};
    // A transaction start outranks a byte in the same cycle
    assign wr_commit = wr_byte_valid && !xfer_start && ((phase_r == adc_pkg::ph_data_lo)
                       || (phase_r == adc_pkg::ph_data_hi && !wide_sel));

    // Write byte sequencing
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phase_r <= adc_pkg::ph_idle;
            sel_r <= 3'(`PTR_RESET);
            hi_byte_r <= 8'h00;
        end else if (xfer_start) begin
            phase_r <= adc_pkg::ph_pointer;
        end else if (wr_byte_valid) begin
            case (phase_r)
                adc_pkg::ph_pointer: begin
                    sel_r <= wr_byte[2:0];
                    phase_r <= adc_pkg::ph_data_hi;
                end
                adc_pkg::ph_data_hi: begin
                    hi_byte_r <= wr_byte;
                    phase_r <= wide_sel ? adc_pkg::ph_data_lo : adc_pkg::ph_data_hi;
                end
                adc_pkg::ph_data_lo: phase_r <= adc_pkg::ph_data_hi;
                default: phase_r <= adc_pkg::ph_idle;
            endcase
        end
    end

    // Writable registers; result is never written by the host
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            config_r <= `CONFIG_RESET;
            low_r <= `LOW_RESET;
            high_r <= `HIGH_RESET;
            hyst_r <= `HYST_RESET;
        end else if (powerdown) begin
            config_r <= `CONFIG_RESET;
            low_r <= `LOW_RESET;
            high_r <= `HIGH_RESET;
            hyst_r <= `HYST_RESET;
        end else if (wr_commit) begin
            case (sel_r)
                `SEL_CONFIG: config_r <= wr_byte & ~(8'h01 << `CFG_RSVD_BIT);
                `SEL_LOW: low_r <= wr_word;
                `SEL_HIGH: high_r <= wr_word;
                `SEL_HYST: hyst_r <= wr_word;
                default: config_r <= config_r;
            endcase
        end
    end

    // Result and running extremes follow each finished conversion
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            result_r <= `RESULT_RESET;
            lowest_r <= `LOWEST_RESET;
            highest_r <= `HIGHEST_RESET;
        end else if (powerdown) begin
            result_r <= `RESULT_RESET;
            lowest_r <= `LOWEST_RESET;
            highest_r <= `HIGHEST_RESET;
        end else begin
            if (conv_done) begin
                result_r <= conv_sample;
            end
            // Host write loses to a same-cycle sample that sets a new extreme, so no extreme is missed
            if (conv_done && conv_sample < lowest_r) begin
                lowest_r <= conv_sample;
            end else if (wr_commit && sel_r == `SEL_LOWEST) begin
                lowest_r <= wr_word;
            end
            if (conv_done && conv_sample > highest_r) begin
                highest_r <= conv_sample;
            end else if (wr_commit && sel_r == `SEL_HIGHEST) begin
                highest_r <= wr_word;
            end
        end
    end

    assign lim.sample_valid = conv_done;
    assign lim.sample = conv_sample;
    assign lim.low_value = low_r;
    assign lim.high_value = high_r;
    assign lim.hyst_value = hyst_r;
    assign lim.hold = config_r[`CFG_HOLD_BIT];
    // Bits 7:2 of a status write are ignored
    assign lim.clear_w1 = (wr_commit && sel_r == `SEL_STATUS) ? wr_byte[1:0] : 2'b00;

    // Read bytes, high byte first; the next transaction restarts at the high byte
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_byte_r <= 8'h00;
            rd_byte_valid_r <= 1'b0;
            rd_lo_r <= 1'b0;
            conv_start_r <= 1'b0;
        end else begin
            rd_byte_valid_r <= rd_byte_req;
            conv_start_r <= 1'b0;
            if (xfer_start) begin
                rd_lo_r <= 1'b0;
            end else if (rd_byte_req) begin
                if (!wide_sel) begin
                    rd_byte_r <= word_sel[7:0];
                end else if (!rd_lo_r) begin
                    rd_byte_r <= word_sel[15:8];
                    rd_lo_r <= 1'b1;
                end else begin
                    rd_byte_r <= word_sel[7:0];
                    rd_lo_r <= 1'b0;
                    // Completed result read launches the next sample unless automatic mode is set
                    conv_start_r <= (sel_r == `SEL_RESULT) && !auto_mode;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            alert_active_r <= 1'b0;
        end else begin
            alert_active_r <= |flags;
        end
    end
endmodule : adc_reg_bank

// File: tb/adc_reg_bank_properties.sv
// Port-level assertions for the converter register bank.
// Assumes one clock domain and the bind below.
`timescale 1ns/1ps
module adc_reg_bank_check #(
    parameter int SAMPLE_W = 12
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic xfer_start,
    input wire logic wr_byte_valid,
    input wire logic [7:0] wr_byte,
    input wire logic rd_byte_req,
    input wire logic [7:0] rd_byte_r,
    input wire logic rd_byte_valid_r,
    input wire logic conv_start_r,
    input wire logic conv_done,
    input wire logic [SAMPLE_W-1:0] conv_sample,
    input wire logic powerdown,
    input wire logic alert_active_r
);
    logic [2:0] wr_hist_r;
    logic [2:0] done_hist_r;
    // Short history: flag updates land a cycle or two after their cause
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_hist_r <= 3'h0;
            done_hist_r <= 3'h0;
        end else begin
            wr_hist_r <= {wr_hist_r[1:0], wr_byte_valid};
            done_hist_r <= {done_hist_r[1:0], conv_done};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_rd_answer_due: assert property (rd_byte_req |=> rd_byte_valid_r)
        else $error("read byte not answered next cycle");
    a_rd_answer_caused: assert property (rd_byte_valid_r |-> $past(rd_byte_req))
        else $error("read byte without request");
    a_rd_answer_single: assert property (rd_byte_req ##1 !rd_byte_req |=> !rd_byte_valid_r)
        else $error("read valid longer than one cycle");
    a_rd_byte_held: assert property (!rd_byte_valid_r |-> $stable(rd_byte_r))
        else $error("read byte changed without valid");
    a_conv_start_pulse: assert property (conv_start_r |=> !conv_start_r)
        else $error("conversion start longer than one cycle");
    a_conv_start_read: assert property (conv_start_r |-> rd_byte_valid_r)
        else $error("conversion start without a read byte");
    a_alert_rise_cause: assert property ($rose(alert_active_r) |-> |done_hist_r)
        else $error("alert rose without a conversion");
    a_alert_fall_cause: assert property ($fell(alert_active_r) |-> |{wr_hist_r, done_hist_r})
        else $error("alert fell without write or conversion");
endmodule : adc_reg_bank_check
bind adc_reg_bank adc_reg_bank_check #(.SAMPLE_W(SAMPLE_W)) chk_i (.clock(clock), .rst_b(rst_b),
    .xfer_start(xfer_start), .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
    .rd_byte_req(rd_byte_req), .rd_byte_r(rd_byte_r), .rd_byte_valid_r(rd_byte_valid_r),
    .conv_start_r(conv_start_r), .conv_done(conv_done), .conv_sample(conv_sample),
    .powerdown(powerdown), .alert_active_r(alert_active_r));

// File: tb/bus_host.sv
// Byte-level stand-in for the two-wire bus controller.
// Assumes the bank samples on rising edges; drives on falling edges.
`timescale 1ns/1ps
module bus_host (
    input wire logic clock,
    output logic xfer_start,
    output logic wr_byte_valid,
    output logic [7:0] wr_byte,
    output logic rd_byte_req,
    input wire logic [7:0] rd_byte,
    input wire logic rd_valid
);
    initial begin
        xfer_start = 1'b0;
        wr_byte_valid = 1'b0;
        wr_byte = 8'h00;
        rd_byte_req = 1'b0;
    end
    task automatic begin_xfer();
        @(negedge clock) xfer_start = 1'b1;
        @(negedge clock) xfer_start = 1'b0;
    endtask : begin_xfer
    // Pointer byte, then n data bytes high first; valid held across bytes
    task automatic write_seq(input logic [2:0] sel, input int n, input logic [15:0] d);
        begin_xfer();
        wr_byte_valid = 1'b1;
        wr_byte = {5'h00, sel};
        for (int i = n; i > 0; i--) begin
            @(negedge clock) wr_byte = d[8*i-1 -: 8];
        end
        @(negedge clock) wr_byte_valid = 1'b0;
        wr_byte = ~wr_byte; // Released data never keeps its last value
    endtask : write_seq
    task automatic read_seq(input int n, output logic [15:0] d);
        begin_xfer();
        d = 16'h0000;
        for (int i = 0; i < n; i++) begin
            rd_byte_req = 1'b1;
            @(negedge clock) d = {d[7:0], (rd_valid === 1'b1) ? rd_byte : 8'hxx};
            rd_byte_req = 1'b0;
            @(negedge clock);
        end
    endtask : read_seq
endmodule : bus_host

// File: tb/test_adc_reg_bank.sv
// Self-checking bench for the converter register bank.
// Assumes the bus_host model and the bound checker.
`timescale 1ns/1ps
module test_adc_reg_bank;
    logic clock, rst_b, xfer_start, wr_byte_valid, rd_byte_req, rd_byte_valid_r;
    logic conv_start_r, conv_done, powerdown, alert_active_r;
    logic [7:0] wr_byte, rd_byte_r;
    logic [11:0] conv_sample;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] start_cnt = 16'h0000;
    adc_reg_bank uut (.clock(clock), .rst_b(rst_b), .xfer_start(xfer_start),
        .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .rd_byte_req(rd_byte_req),
        .rd_byte_r(rd_byte_r), .rd_byte_valid_r(rd_byte_valid_r), .conv_start_r(conv_start_r),
        .conv_done(conv_done), .conv_sample(conv_sample), .powerdown(powerdown),
        .alert_active_r(alert_active_r));
    bus_host host (.clock(clock), .xfer_start(xfer_start), .wr_byte_valid(wr_byte_valid),
        .wr_byte(wr_byte), .rd_byte_req(rd_byte_req), .rd_byte(rd_byte_r),
        .rd_valid(rd_byte_valid_r));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Start pulses stand one cycle, so each falling edge sees one at most
    always @(negedge clock) begin
        if (conv_start_r === 1'b1) start_cnt = start_cnt + 16'h0001;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic rd_reg(input logic [2:0] sel, input logic [15:0] exp);
        logic [15:0] d;
        host.write_seq(sel, 0, 16'h0000);
        host.read_seq((sel == 3'h1 || sel == 3'h2) ? 1 : 2, d);
        chk(d, exp);
    endtask : rd_reg
    task automatic convert(input logic [11:0] s);
        @(negedge clock) conv_done = 1'b1;
        conv_sample = s;
        @(negedge clock) conv_done = 1'b0;
        conv_sample = ~s;
        repeat (3) @(negedge clock);
    endtask : convert
    task automatic test_defaults();
        logic [15:0] d;
        logic [15:0] exp [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                 16'h0FFF, 16'h0000, 16'h0FFF, 16'h0000};
        host.read_seq(2, d);
        chk(d, 16'h0000);
        for (int i = 1; i < 8; i++) rd_reg(3'(i), exp[i]);
    endtask : test_defaults
    task automatic test_write();
        host.write_seq(3'h3, 2, 16'h0123);
        host.write_seq(3'h5, 2, 16'h0045);
        host.write_seq(3'h0, 2, 16'h0ABC);
        rd_reg(3'h0, 16'h0000);
        rd_reg(3'h3, 16'h0123);
        rd_reg(3'h5, 16'h0045);
    endtask : test_write
    task automatic test_alerts();
        host.write_seq(3'h4, 2, 16'h0800);
        host.write_seq(3'h3, 2, 16'h0100);
        host.write_seq(3'h5, 2, 16'h0010);
        host.write_seq(3'h2, 1, 16'h0008);
        convert(12'h123);
        rd_reg(3'h0, 16'h0123);
        convert(12'h900);
        rd_reg(3'h1, 16'h0002);
        chk_bit(alert_active_r, 1'b1);
        rd_reg(3'h0, 16'h8900);
        convert(12'h7F8);
        rd_reg(3'h1, 16'h0002);
        convert(12'h7E0);
        rd_reg(3'h1, 16'h0000);
        convert(12'h050);
        rd_reg(3'h1, 16'h0001);
        convert(12'h120);
        rd_reg(3'h1, 16'h0000);
        convert(12'h050);
        host.write_seq(3'h1, 1, 16'h0001);
        rd_reg(3'h1, 16'h0000);
        host.write_seq(3'h2, 1, 16'h0010);
        convert(12'h900);
        convert(12'h400);
        rd_reg(3'h1, 16'h0002);
        rd_reg(3'h0, 16'h0400);
        host.write_seq(3'h1, 1, 16'h0002);
        rd_reg(3'h1, 16'h0000);
        chk_bit(alert_active_r, 1'b0);
    endtask : test_alerts
    task automatic test_conv_start();
        logic [15:0] base;
        base = start_cnt;
        rd_reg(3'h1, 16'h0000);
        rd_reg(3'h0, 16'h0400);
        chk(start_cnt - base, 16'h0001);
        // Reserved bit 1 must not stick; cycle bits select automatic mode
        host.write_seq(3'h2, 1, 16'h0032);
        rd_reg(3'h2, 16'h0030);
        base = start_cnt;
        rd_reg(3'h0, 16'h0400);
        chk(start_cnt - base, 16'h0000);
    endtask : test_conv_start
    task automatic test_powerdown();
        @(negedge clock) powerdown = 1'b1;
        @(negedge clock) powerdown = 1'b0;
        rd_reg(3'h4, 16'h0FFF);
        rd_reg(3'h2, 16'h0000);
    endtask : test_powerdown
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        rst_b = 1'b0;
        conv_done = 1'b0;
        conv_sample = 12'h000;
        powerdown = 1'b0;
        repeat (8) @(negedge clock);
        rst_b = 1'b1;
        test_defaults();
        test_write();
        test_alerts();
        test_conv_start();
        test_powerdown();
        give_verdict();
    end
endmodule : test_adc_reg_bank
